// ---- shared/rdt_pkg.sv ----
// register map, field positions and reset values of the reload down timer
package rdt_pkg;
  localparam logic [7:0] ADDR_CLK = 8'h00;
  localparam logic [7:0] ADDR_MOD = 8'h04;
  localparam logic [7:0] ADDR_CTL = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [7:0] ADDR_IE = 8'h18;
  localparam int BIT_DEBUG_KEEP = 8;
  localparam int BIT_DIV_LO = 4;
  localparam int BIT_RUN = 8;
  localparam int BIT_PRESET = 1;
  localparam int BIT_ENABLE = 0;
  localparam logic [15:0] RESET_RELOAD = 16'hffff;
  localparam logic [15:0] RESET_COUNT = 16'hffff;
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOW = 2'h1;
  localparam logic [1:0] SRC_HIGH = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  typedef struct packed {
    logic debug_clock_keep;
    logic [3:0] prescale_code;
    logic [1:0] count_clock_source;
  } rdt_clk_cfg_t;
endpackage

// ---- rtl/rdt_timer.sv ----
// one channel of a 16-bit reloadable down timer with apb registers
// Summary of operation
// - debug keep bit keeps clock in debug
// - prescaler divides internal and high speed sources by 2^code
// - source field selects one of four clocks
// - source 3 uses event or external clock
// - absent sources refused on write; reset selects source 0 even if absent
// - mode bit one selects one-shot
// - run bit starts, stops, reads status
// - one-shot underflow clears run bit
// - preset copies reload, reads busy meanwhile
// - channel enable gates operating clock
// - reload loads on preset and underflow
// - counter register read only, reset ffff
// - underflow flag set, write one clears
// - enable bit gates underflow interrupt
// - counter decrements per tick, pulses underflow
// - repeat mode reloads and keeps counting
// - one-shot stops after reload on underflow
// - irq only when flag and enable set
`timescale 1ns/1ps
module rdt_timer #(
  parameter int CNT_W = 16,
  parameter bit HAS_INTERNAL = 1'b1,
  parameter bit HAS_LOW = 1'b1,
  parameter bit HAS_HIGH = 1'b1,
  parameter bit HAS_EXT = 1'b1,
  parameter bit HAS_EVENT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // source ticks, one-cycle enables synchronous to pclk (event input edge-detected), then cpu debug level
  input wire logic internal_oscillator,
  input wire logic low_speed_oscillator,
  input wire logic high_speed_oscillator,
  input wire logic external_clock_input,
  input wire logic event_count_input,
  input wire logic cpu_debug,
  // events
  output logic underflow_pulse,
  output logic irq
);
  rdt_pkg::rdt_clk_cfg_t clk_cfg;
  logic one_shot_select;
  logic run_bit;
  logic channel_enable;
  logic preset_busy;
  logic [CNT_W-1:0] reload_field;
  logic [CNT_W-1:0] count_field;
  logic underflow_flag_bit;
  logic underflow_enable_bit;
  logic [14:0] prescale_cnt;
  logic event_q;
  logic src_tick;
  logic channel_operating_clock;
  logic count_tick;
  logic uf_now;

  wire logic wr = psel && penable && pwrite && clk_en;

  function automatic logic src_ok(input logic [1:0] s);
    case (s)
      rdt_pkg::SRC_INTERNAL: src_ok = HAS_INTERNAL;
      rdt_pkg::SRC_LOW: src_ok = HAS_LOW;
      rdt_pkg::SRC_HIGH: src_ok = HAS_HIGH;
      default: src_ok = HAS_EXT || HAS_EVENT;
    endcase
  endfunction

  // source pick; external path stays undivided
  always_comb begin
    case (clk_cfg.count_clock_source)
      rdt_pkg::SRC_INTERNAL: src_tick = internal_oscillator;
      rdt_pkg::SRC_LOW: src_tick = low_speed_oscillator;
      rdt_pkg::SRC_HIGH: src_tick = high_speed_oscillator;
      default: src_tick = HAS_EVENT ? (event_count_input && !event_q) : external_clock_input;
    endcase
  end

  // clock gate: enable and debug hold
  assign channel_operating_clock = channel_enable && (!cpu_debug || clk_cfg.debug_clock_keep);
  wire logic div_done = (clk_cfg.count_clock_source == rdt_pkg::SRC_EXT) ||
    (clk_cfg.count_clock_source == rdt_pkg::SRC_LOW) ||
    (prescale_cnt == 15'((32'h1 << clk_cfg.prescale_code) - 1));
  assign count_tick = channel_operating_clock && src_tick && div_done;
  assign uf_now = count_tick && run_bit && (count_field == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else if (clk_en) begin
      event_q <= event_count_input;
    end
  end

  // low speed source has no divider column, kept undivided
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= '0;
    end else if (clk_en && channel_operating_clock && src_tick) begin
      prescale_cnt <= div_done ? '0 : prescale_cnt + 15'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg <= '0;
      one_shot_select <= 1'b0;
      channel_enable <= 1'b0;
      reload_field <= rdt_pkg::RESET_RELOAD;
      underflow_enable_bit <= 1'b0;
    end else if (wr) begin
      case (paddr)
        rdt_pkg::ADDR_CLK: begin
          clk_cfg.debug_clock_keep <= pwdata[rdt_pkg::BIT_DEBUG_KEEP];
          clk_cfg.prescale_code <= pwdata[rdt_pkg::BIT_DIV_LO +: 4];
          if (src_ok(pwdata[1:0])) begin
            clk_cfg.count_clock_source <= pwdata[1:0];
          end
        end
        rdt_pkg::ADDR_MOD: one_shot_select <= pwdata[0];
        rdt_pkg::ADDR_CTL: channel_enable <= pwdata[rdt_pkg::BIT_ENABLE];
        rdt_pkg::ADDR_RELOAD: reload_field <= pwdata[CNT_W-1:0];
        rdt_pkg::ADDR_IE: underflow_enable_bit <= pwdata[0];
        default: ;
      endcase
    end
  end

  // enable must already be set or come in the same write
  wire logic ctl_wr = wr && (paddr == rdt_pkg::ADDR_CTL);
  wire logic en_next = ctl_wr ? pwdata[rdt_pkg::BIT_ENABLE] : channel_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_bit <= 1'b0;
    end else if (clk_en) begin
      if (uf_now && one_shot_select) begin
        run_bit <= 1'b0;
      end else if (ctl_wr) begin
        run_bit <= pwdata[rdt_pkg::BIT_RUN] && en_next;
      end
    end
  end

  // preset takes one cycle; busy reads one meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_busy <= 1'b0;
    end else if (clk_en) begin
      preset_busy <= ctl_wr && pwdata[rdt_pkg::BIT_PRESET] && en_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_field <= rdt_pkg::RESET_COUNT;
    end else if (clk_en) begin
      if (preset_busy || uf_now) begin
        count_field <= reload_field;
      end else if (count_tick && run_bit) begin
        count_field <= count_field - CNT_W'(1);
      end
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_flag_bit <= 1'b0;
    end else if (clk_en) begin
      if (uf_now) begin
        underflow_flag_bit <= 1'b1;
      end else if (wr && paddr == rdt_pkg::ADDR_FLAG && pwdata[0]) begin
        underflow_flag_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_pulse <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      underflow_pulse <= uf_now;
      irq <= (underflow_flag_bit || uf_now) && (wr && paddr == rdt_pkg::ADDR_IE ? pwdata[0] :
        underflow_enable_bit) && !(wr && paddr == rdt_pkg::ADDR_FLAG && pwdata[0] && !uf_now);
    end
  end

  // zero wait state slave; reserved bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > rdt_pkg::ADDR_IE;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          rdt_pkg::ADDR_CLK: prdata <= {23'h0, clk_cfg.debug_clock_keep,
            clk_cfg.prescale_code, 2'h0, clk_cfg.count_clock_source};
          rdt_pkg::ADDR_MOD: prdata <= {31'h0, one_shot_select};
          rdt_pkg::ADDR_CTL: prdata <= {23'h0, run_bit, 6'h0, preset_busy, channel_enable};
          rdt_pkg::ADDR_RELOAD: prdata <= 32'(reload_field);
          rdt_pkg::ADDR_COUNT: prdata <= 32'(count_field);
          rdt_pkg::ADDR_FLAG: prdata <= {31'h0, underflow_flag_bit};
          rdt_pkg::ADDR_IE: prdata <= {31'h0, underflow_enable_bit};
          default: prdata <= '0;
        endcase
      end
    end
  end

  a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && uf_now && one_shot_select |=> !run_bit)
    else $error("one-shot underflow left run set");
  a_reload_load: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && uf_now |=> count_field == $past(reload_field))
    else $error("underflow did not reload");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && uf_now |=> underflow_flag_bit)
    else $error("underflow flag not set");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(underflow_flag_bit || uf_now))
    else $error("irq without cause");
  a_preset_done: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && preset_busy |=> count_field == $past(reload_field) && (!clk_en || !preset_busy))
    else $error("preset did not complete");
  a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && count_tick && run_bit && !preset_busy && count_field != '0
    |=> count_field == $past(count_field) - 1'b1)
    else $error("counter did not decrement");
  a_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !channel_enable && !preset_busy |=> $stable(count_field))
    else $error("counter moved while disabled");
  a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == rdt_pkg::ADDR_COUNT && !uf_now && !count_tick && !preset_busy
    |=> $stable(count_field))
    else $error("counter register was written");

  // low enable must freeze every piece of state, bus side included
  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(count_field) && $stable(run_bit) && $stable(underflow_flag_bit)
    && $stable(prdata))
    else $error("state moved while clock enable low");
  // irq follows the next flag and enable together, so no lag to allow for
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (underflow_flag_bit && underflow_enable_bit))
    else $error("irq differs from flag and enable");
  // run can only be seen set with the channel enabled
  a_run_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(run_bit) |-> channel_enable)
    else $error("run set without channel enable");
  // writing zero to run always stops the count
  a_ctl_stop: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr && !pwdata[rdt_pkg::BIT_RUN] |=> !run_bit)
    else $error("run not cleared by write");
  // absent sources are refused at the write
  a_source_legal: assert property (@(posedge pclk) disable iff (!presetn)
    src_ok(clk_cfg.count_clock_source))
    else $error("absent clock source selected");
  // stopped counter only moves on a preset
  a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !run_bit && !preset_busy |=> $stable(count_field))
    else $error("stopped counter moved");
  // pulse is what another peripheral may take as a clock
  a_pulse_out: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && uf_now |=> underflow_pulse)
    else $error("underflow pulse missing");
  // zero wait state: ready always answers the setup cycle
  a_pready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable |=> pready)
    else $error("ready not raised in access cycle");
  // offsets above the IE register answer with an error, never a hang
  a_slverr_range: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable && paddr > rdt_pkg::ADDR_IE |=> pslverr)
    else $error("no error for unmapped offset");
  // clear only loses to a same-cycle underflow
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == rdt_pkg::ADDR_FLAG && pwdata[0] && !uf_now
    |=> !underflow_flag_bit)
    else $error("flag not cleared by write one");
  // busy must be visible for the cycle of the copy
  a_preset_busy: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr && pwdata[rdt_pkg::BIT_PRESET] && en_next |=> preset_busy)
    else $error("preset busy not raised");
  // debug without keep withholds the counting clock
  a_debug_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cpu_debug && !clk_cfg.debug_clock_keep && !preset_busy |=> $stable(count_field))
    else $error("counter moved in debug");
endmodule

// ---- dv/reloadable_down_timer_test.sv ----
// self-checking bench of the reload down timer channel
`timescale 1ns/1ps
module reloadable_down_timer_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] tk = 4'h0;
  logic dbg = 1'b0;
  logic ce = 1'b1;
  logic underflow_pulse;
  logic irq;
  logic [31:0] rd;
  logic [31:0] rl;
  logic slv;
  logic [15:0] lf = 16'h000a;
  logic [31:0] rst_tab [7] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0};
  int error_cnt = 0;
  int compares = 0;
  int p;
  always #2 pclk = ~pclk;
  rdt_timer u_rdt_timer (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_oscillator(tk[0]),
    .low_speed_oscillator(tk[1]), .high_speed_oscillator(tk[2]),
    .external_clock_input(tk[3]), .event_count_input(1'b0), .cpu_debug(dbg),
    .underflow_pulse(underflow_pulse), .irq(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge after it keeps psel from being set twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("BAD %0t no ready", $time);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // cycles between two underflow pulses, 0 if none came
  task automatic period(output int q);
    int n;
    n = 0;
    q = 0;
    while (underflow_pulse !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    if (n < 600) begin
      @(posedge pclk);
      q = 1;
      while (underflow_pulse !== 1'b1 && q < 600) begin
        @(posedge pclk);
        q++;
      end
    end
  endtask
  // reload only changes while stopped
  task automatic run(input logic [31:0] cfg, input logic [31:0] mode);
    apb(1'b1, rdt_pkg::ADDR_CTL, 32'h1);
    apb(1'b1, rdt_pkg::ADDR_RELOAD, rl);
    apb(1'b1, rdt_pkg::ADDR_CLK, cfg);
    apb(1'b1, rdt_pkg::ADDR_MOD, mode);
    apb(1'b1, rdt_pkg::ADDR_CTL, 32'h3);
    apb(1'b0, rdt_pkg::ADDR_COUNT, 32'h0);
    check(rd, rl);
    apb(1'b1, rdt_pkg::ADDR_CTL, 32'h101);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, rst_tab[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, slv}, 32'h1);
    apb(1'b1, rdt_pkg::ADDR_COUNT, 32'h0);
    apb(1'b0, rdt_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'hffff);
    for (int s = 0; s < 4; s++) begin
      lf = lfsr(lf);
      rl = {27'h0, lf[4:0]} + 32'h1;
      tk <= 4'(1 << s);
      run(32'h10 | 32'(s), 32'h0);
      period(p);
      check(32'(p), (rl + 1) * ((s == 0 || s == 2) ? 2 : 1));
    end
    // freeze the running channel for a while; the freeze assertion watches it
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    apb(1'b0, rdt_pkg::ADDR_CTL, 32'h0);
    check(rd & 32'h103, 32'h101);
    apb(1'b1, rdt_pkg::ADDR_CTL, 32'h1);
    apb(1'b0, rdt_pkg::ADDR_CTL, 32'h0);
    check(rd, 32'h1);
    tk <= 4'h2;
    run(32'h0, 32'h0);
    period(p);
    check(32'(p), 32'h0);
    tk <= 4'h1;
    run(32'h0, 32'h0);
    dbg <= 1'b1;
    period(p);
    check(32'(p), 32'h0);
    run(32'h100, 32'h0);
    period(p);
    check(32'(p), rl + 1);
    dbg <= 1'b0;
    apb(1'b1, rdt_pkg::ADDR_CTL, 32'h100);
    period(p);
    check(32'(p), 32'h0);
    apb(1'b0, rdt_pkg::ADDR_FLAG, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, rdt_pkg::ADDR_IE, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, rdt_pkg::ADDR_FLAG, 32'h0);
    apb(1'b0, rdt_pkg::ADDR_FLAG, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, rdt_pkg::ADDR_FLAG, 32'h1);
    apb(1'b0, rdt_pkg::ADDR_FLAG, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    // a single pulse then silence means the first wait ends and the second runs out
    run(32'h0, 32'h1);
    period(p);
    check(32'(p), 32'd600);
    apb(1'b0, rdt_pkg::ADDR_CTL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, rdt_pkg::ADDR_COUNT, 32'h0);
    check(rd, rl);
    tally_and_finish();
  end
endmodule
